// [src/vstx_defs.svh]
`ifndef VSTX_DEFS_SVH
`define VSTX_DEFS_SVH

// Standard select codes.
`define VSTX_STD_SD 3'h0
`define VSTX_STD_HD 3'h1
`define VSTX_STD_3GB 3'h2
`define VSTX_STD_3GA 3'h3
`define VSTX_STD_6G8 3'h4
`define VSTX_STD_6G4 3'h5
`define VSTX_STD_12G16 3'h6
`define VSTX_STD_12G8 3'h7

// Word and lane geometry.
`define VSTX_FIELD_W 10
`define VSTX_LANE_W 20
`define VSTX_LANES_MULTI 4
`define VSTX_LANES_OTHER 1
`define VSTX_FIELDS_A 8
`define VSTX_FIELDS 10

// Word positions after the first word of a timing reference.
`define VSTX_POS_XYZ 4'h3
`define VSTX_POS_LN0 4'h4
`define VSTX_POS_LN1 4'h5
`define VSTX_POS_CRC0 4'h6
`define VSTX_POS_CRC1 4'h7
`define VSTX_POS_MAX 4'hF
`define VSTX_H_BIT 6

// Line CRC, x^18 + x^5 + x^4 + 1, shifted in lsb first.
`define VSTX_CRC_TAPS 18'h23000
`define VSTX_CRC_RESET 18'h00000

// Valid cadence counts: SD repeats every 11 words, high at 0 and 5.
`define VSTX_SD_PERIOD 4'hB
`define VSTX_SD_HIGH0 4'h0
`define VSTX_SD_HIGH1 4'h5

`endif

// [src/vstx_pkg.sv]
package vstx_pkg;

    typedef enum logic [2:0] {
        STD_SD = 3'h0,
        STD_HD = 3'h1,
        STD_3GB = 3'h2,
        STD_3GA = 3'h3,
        STD_6G8 = 3'h4,
        STD_6G4 = 3'h5,
        STD_12G16 = 3'h6,
        STD_12G8 = 3'h7
    } vstx_std_t;

    typedef enum logic [2:0] {
        BUILD_SD = 3'h0,
        BUILD_HD = 3'h1,
        BUILD_HD_DUAL = 3'h2,
        BUILD_3G = 3'h3,
        BUILD_DUAL_RATE = 3'h4,
        BUILD_TRIPLE_RATE = 3'h5,
        BUILD_MULTI_RATE = 3'h6
    } vstx_build_t;

    typedef struct packed {
        logic [79:0] data;
        logic [19:0] data_b;
        logic valid;
        logic valid_b;
        logic trs;
        logic trs_b;
    } vstx_stream_t;

endpackage

// [src/vstx_valid_gen.sv]
`timescale 1ns/1ns
`include "vstx_defs.svh"

module vstx_valid_gen (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire vstx_pkg::vstx_std_t i_std,
    input wire logic i_rate_switch,
    output logic o_valid
);

    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    vstx_pkg::vstx_std_t std_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Word counter restarts whenever the standard changes so the cadence starts clean.
    always_comb begin
        cnt_next = cnt_reg + 4'h1;
        if (cnt_next == `VSTX_SD_PERIOD || i_std != std_reg) begin
            cnt_next = 4'h0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg <= 4'h0;
            std_reg <= vstx_pkg::STD_SD;
        end else begin
            cnt_reg <= cnt_next;
            std_reg <= i_std;
        end
    end

    // Cadence: SD one high, four low, one high, five low; HD in dual-, triple- and multi-rate builds is high on the even counts 0 to 10 of the 11-count cycle.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
        end else if (i_std == vstx_pkg::STD_SD) begin
            o_valid <= (cnt_next == `VSTX_SD_HIGH0) || (cnt_next == `VSTX_SD_HIGH1);
        end else if (i_std == vstx_pkg::STD_HD && i_rate_switch) begin
            o_valid <= ~cnt_next[0];
        end else begin
            o_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_sd_cadence;
        @(posedge i_clk) disable iff (i_rst)
        (i_std == vstx_pkg::STD_SD) [*8] ##1 (i_std == vstx_pkg::STD_SD && o_valid && $past(o_valid, 5))
        |-> ##1 !o_valid [*5];
    endproperty
    a_sd_cadence: assert property (p_sd_cadence) else $error("SD valid gap is not five low");

    property p_hi_rate_valid;
        @(posedge i_clk) disable iff (i_rst)
        (i_std != vstx_pkg::STD_SD && i_std != vstx_pkg::STD_HD) [*2] |-> o_valid;
    endproperty
    a_hi_rate_valid: assert property (p_hi_rate_valid) else $error("valid not held high above HD");

endmodule

// [src/vstx_input.sv]
`timescale 1ns/1ns
`include "vstx_defs.svh"

// Notes on behaviour
// - All inputs sampled only on the parallel clock.
// - CRC inserted when enabled, except in SD.
// - Line number inserted when enabled, except SD.
// - Select: 000 SD, 001 HD, 011 3GA, 010 3GB.
// - Select: 101 6G four, 100 6G eight streams.
// - Select: 111 12G eight, 110 12G sixteen.
// - Select used only by multi-standard builds.
// - Data is four 20-bit lanes multi-rate, else one.
// - Transceiver-only builds pass words unscrambled, untouched.
// - Device generates cadence valid per standard.
module vstx_input #(
    parameter vstx_pkg::vstx_build_t BUILD = vstx_pkg::BUILD_MULTI_RATE,
    parameter vstx_pkg::vstx_std_t FIXED_STD = vstx_pkg::STD_HD,
    parameter bit XCVR_ONLY = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_std,
    input wire logic i_crc_insert_enable,
    input wire logic i_line_number_insert_enable,
    input wire logic [10:0] i_line_number,
    input wire vstx_pkg::vstx_stream_t i_stream,
    output vstx_pkg::vstx_stream_t o_stream,
    output vstx_pkg::vstx_std_t o_std,
    output logic o_valid_gen,
    output logic o_valid_gen_b
);

    localparam bit STD_SELECT = (BUILD == vstx_pkg::BUILD_3G) || (BUILD == vstx_pkg::BUILD_DUAL_RATE) ||
        (BUILD == vstx_pkg::BUILD_TRIPLE_RATE) || (BUILD == vstx_pkg::BUILD_MULTI_RATE);
    localparam bit RATE_SWITCH = (BUILD == vstx_pkg::BUILD_DUAL_RATE) ||
        (BUILD == vstx_pkg::BUILD_TRIPLE_RATE) || (BUILD == vstx_pkg::BUILD_MULTI_RATE);
    localparam int LANES = (BUILD == vstx_pkg::BUILD_MULTI_RATE) ? `VSTX_LANES_MULTI : `VSTX_LANES_OTHER;
    localparam bit DUAL_LINK = (BUILD == vstx_pkg::BUILD_HD_DUAL);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Number of 10-bit fields of link A that carry video for a standard.
    function automatic logic [3:0] field_count(input vstx_pkg::vstx_std_t s);
        logic [3:0] n;
        case (s)
            vstx_pkg::STD_SD: n = 4'h1;
            vstx_pkg::STD_6G4, vstx_pkg::STD_6G8: n = 4'h4;
            vstx_pkg::STD_12G8, vstx_pkg::STD_12G16: n = 4'h8;
            default: n = 4'h2;
        endcase
        if (n > 4'(2 * LANES)) begin
            n = 4'(2 * LANES);
        end
        return n;
    endfunction

    // Advance a line CRC by one 10-bit word, lsb first.
    function automatic logic [17:0] crc_word(input logic [17:0] c, input logic [9:0] d);
        logic [17:0] r;
        r = c;
        for (int i = 0; i < `VSTX_FIELD_W; i++) begin
            r = (r >> 1) ^ ((r[0] ^ d[i]) ? `VSTX_CRC_TAPS : 18'h00000);
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Standard decode.

    vstx_pkg::vstx_std_t std_cur;
    logic dbl;
    logic [3:0] nfield;
    logic insert_ok;

    // Single-standard builds ignore the select and run their fixed standard.
    assign std_cur = STD_SELECT ? vstx_pkg::vstx_std_t'(i_std) : FIXED_STD;
    assign dbl = (std_cur == vstx_pkg::STD_3GB) || (std_cur == vstx_pkg::STD_6G8) ||
        (std_cur == vstx_pkg::STD_12G16);
    assign nfield = field_count(std_cur);
    assign insert_ok = !XCVR_ONLY && (std_cur != vstx_pkg::STD_SD);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_std <= vstx_pkg::STD_SD;
        end else begin
            o_std <= std_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timing reference tracking: word position since the first word of EAV or SAV.

    logic trs_prev_reg;
    logic half_reg;
    logic [3:0] pos_reg;
    logic eav_reg;
    logic start;
    logic half_cur;
    logic tick;
    logic [3:0] pos_cur;

    assign start = i_stream.trs && !trs_prev_reg;
    assign half_cur = start ? 1'b0 : half_reg;
    assign pos_cur = start ? 4'h0 : pos_reg;
    // Doubled modes hold each word for two cycles, so the position moves on every second valid cycle.
    assign tick = i_stream.valid && (!dbl || half_cur);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            trs_prev_reg <= 1'b0;
            half_reg <= 1'b0;
            pos_reg <= `VSTX_POS_MAX;
        end else begin
            trs_prev_reg <= i_stream.trs;
            half_reg <= (i_stream.valid && dbl) ? ~half_cur : half_cur;
            if (tick && pos_cur != `VSTX_POS_MAX) begin
                pos_reg <= pos_cur + 4'h1;
            end else begin
                pos_reg <= pos_cur;
            end
        end
    end

    // The H bit of the XYZ word tells EAV from SAV.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            eav_reg <= 1'b0;
        end else if (i_stream.valid && pos_cur == `VSTX_POS_XYZ) begin
            eav_reg <= i_stream.data[`VSTX_H_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-field insertion of line number and CRC words.

    logic ln_slot;
    logic crc_slot;
    logic crc_run_reg;
    logic [9:0] in_w [`VSTX_FIELDS];
    logic [9:0] out_w [`VSTX_FIELDS];
    logic [`VSTX_FIELDS-1:0] active;
    logic [17:0] crc_reg [`VSTX_FIELDS];

    assign ln_slot = eav_reg && (pos_cur == `VSTX_POS_LN0 || pos_cur == `VSTX_POS_LN1);
    assign crc_slot = eav_reg && (pos_cur == `VSTX_POS_CRC0 || pos_cur == `VSTX_POS_CRC1);

    // Fields 0 to 7 come from link A lsb upward, fields 8 and 9 from link B.
    always_comb begin
        for (int k = 0; k < `VSTX_FIELDS; k++) begin
            if (k < `VSTX_FIELDS_A) begin
                in_w[k] = i_stream.data[k * `VSTX_FIELD_W +: `VSTX_FIELD_W];
                active[k] = 4'(k) < nfield;
            end else begin
                in_w[k] = i_stream.data_b[(k - `VSTX_FIELDS_A) * `VSTX_FIELD_W +: `VSTX_FIELD_W];
                active[k] = DUAL_LINK;
            end
        end
    end

    // Substitute line number and CRC words; everything else passes unchanged.
    always_comb begin
        for (int k = 0; k < `VSTX_FIELDS; k++) begin
            out_w[k] = in_w[k];
            if (insert_ok && active[k] && i_line_number_insert_enable && ln_slot) begin
                if (pos_cur == `VSTX_POS_LN0) begin
                    out_w[k] = {~i_line_number[6], i_line_number[6:0], 2'h0};
                end else begin
                    out_w[k] = {4'h8, i_line_number[10:7], 2'h0};
                end
            end
            if (insert_ok && active[k] && i_crc_insert_enable && crc_slot) begin
                if (pos_cur == `VSTX_POS_CRC0) begin
                    out_w[k] = {~crc_reg[k][8], crc_reg[k][8:0]};
                end else begin
                    out_w[k] = {~crc_reg[k][17], crc_reg[k][17:9]};
                end
            end
        end
    end

    // CRC runs from the first active word after SAV up to the CRC words of the next EAV.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            crc_run_reg <= 1'b0;
        end else if (i_stream.valid && pos_cur == `VSTX_POS_XYZ && !i_stream.data[`VSTX_H_BIT]) begin
            crc_run_reg <= 1'b1;
        end else if (tick && eav_reg && pos_cur == `VSTX_POS_LN1) begin
            crc_run_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        for (int k = 0; k < `VSTX_FIELDS; k++) begin
            if (i_rst) begin
                crc_reg[k] <= `VSTX_CRC_RESET;
            end else if (i_stream.valid && pos_cur == `VSTX_POS_XYZ && !i_stream.data[`VSTX_H_BIT]) begin
                crc_reg[k] <= `VSTX_CRC_RESET;
            end else if (i_stream.valid && crc_run_reg) begin
                crc_reg[k] <= crc_word(crc_reg[k], out_w[k]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output stage: one register, sampled on the parallel clock only.

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_stream <= '0;
        end else begin
            o_stream <= i_stream;
            if (!XCVR_ONLY) begin
                for (int k = 0; k < `VSTX_FIELDS_A; k++) begin
                    o_stream.data[k * `VSTX_FIELD_W +: `VSTX_FIELD_W] <= out_w[k];
                end
                o_stream.data_b <= {out_w[9], out_w[8]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Generated valid cadence for link A and fixed valid for link B.

    vstx_valid_gen u_valid_a (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_std(std_cur),
        .i_rate_switch(RATE_SWITCH),
        .o_valid(o_valid_gen)
    );

    // Link B only exists in dual link, where its valid is always high.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_valid_gen_b <= 1'b0;
        end else begin
            o_valid_gen_b <= DUAL_LINK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_sd_passthru;
        @(posedge i_clk) disable iff (i_rst)
        (std_cur == vstx_pkg::STD_SD) |=> (o_stream.data == $past(i_stream.data));
    endproperty
    a_sd_passthru: assert property (p_sd_passthru) else $error("SD stream was altered");

    property p_crc0;
        @(posedge i_clk) disable iff (i_rst)
        (insert_ok && i_crc_insert_enable && crc_slot && pos_cur == `VSTX_POS_CRC0)
        |=> (o_stream.data[9:0] == {~$past(crc_reg[0][8]), $past(crc_reg[0][8:0])});
    endproperty
    a_crc0: assert property (p_crc0) else $error("CRC0 word not inserted");

    property p_ln1;
        @(posedge i_clk) disable iff (i_rst)
        (insert_ok && i_line_number_insert_enable && ln_slot && pos_cur == `VSTX_POS_LN1 && !crc_slot)
        |=> (o_stream.data[9:0] == {4'h8, $past(i_line_number[10:7]), 2'h0});
    endproperty
    a_ln1: assert property (p_ln1) else $error("LN1 word not inserted");

    property p_disabled_pass;
        @(posedge i_clk) disable iff (i_rst)
        (!i_crc_insert_enable && !i_line_number_insert_enable) |=> (o_stream == $past(i_stream));
    endproperty
    a_disabled_pass: assert property (p_disabled_pass) else $error("stream altered with insertion off");

    property p_decode_3g;
        @(posedge i_clk) disable iff (i_rst)
        (STD_SELECT && i_std == 3'h2) ##1 (STD_SELECT && i_std == 3'h3)
        |=> (o_std == vstx_pkg::STD_3GA && $past(o_std) == vstx_pkg::STD_3GB);
    endproperty
    a_decode_3g: assert property (p_decode_3g) else $error("3G select decoded wrongly");

    property p_decode_6g;
        @(posedge i_clk) disable iff (i_rst)
        (STD_SELECT && i_std == 3'h5) |=> (o_std == vstx_pkg::STD_6G4 && $past(nfield) == field_count(o_std));
    endproperty
    a_decode_6g: assert property (p_decode_6g) else $error("6G select decoded wrongly");

    property p_decode_12g;
        @(posedge i_clk) disable iff (i_rst)
        (STD_SELECT && i_std == 3'h6) |=> (o_std == vstx_pkg::STD_12G16);
    endproperty
    a_decode_12g: assert property (p_decode_12g) else $error("12G select decoded wrongly");

    property p_fixed_std;
        @(posedge i_clk) disable iff (i_rst)
        !STD_SELECT |=> (o_std == FIXED_STD);
    endproperty
    a_fixed_std: assert property (p_fixed_std) else $error("fixed build followed the select");

    property p_xcvr_raw;
        @(posedge i_clk) disable iff (i_rst)
        XCVR_ONLY |=> (o_stream == $past(i_stream));
    endproperty
    a_xcvr_raw: assert property (p_xcvr_raw) else $error("transceiver-only words altered");

endmodule

// [testbench/vstx_source.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Video source on the far side of the transmit input: one word per valid slot.
module vstx_source (
    input wire logic i_clk,
    input wire logic [2:0] i_std,
    output vstx_pkg::vstx_stream_t o_stream
);
    logic long_gap;

    // Start with every line low so the block never sees an unknown.
    initial begin
        o_stream = '0;
        long_gap = 1'b0;
    end

    // Presents one word after the idle slots that the standard's cadence asks for.
    // Idle slots and unused fields carry inverted data so stale values never pass as good.
    task automatic put(input logic [9:0] f, input logic trs);
        int gaps;
        int nf;
        int k;
        logic [79:0] w;
        logic [79:0] mask;
        gaps = 0;
        nf = 8;
        mask = '0;
        case (i_std)
            3'h0: begin
                gaps = long_gap ? 5 : 4;
                long_gap = ~long_gap;
                nf = 1;
            end
            3'h1: begin
                gaps = 1;
                nf = 2;
            end
            3'h2, 3'h3: nf = 2;
            3'h4, 3'h5: nf = 4;
            default: nf = 8;
        endcase
        for (k = 0; k < 8; k++) begin
            w[10*k +: 10] = f ^ 10'(k);
            mask[10*k +: 10] = (k < nf) ? 10'h3FF : 10'h000;
        end
        repeat (gaps) begin
            o_stream.valid = 1'b0;
            o_stream.trs = 1'b0;
            o_stream.trs_b = 1'b0;
            o_stream.data = ~o_stream.data;
            @(posedge i_clk);
            @(negedge i_clk);
        end
        o_stream.data = (w & mask) | (~o_stream.data & ~mask);
        o_stream.data_b = ~o_stream.data_b;
        o_stream.valid = 1'b1;
        o_stream.valid_b = 1'b1;
        o_stream.trs = trs;
        o_stream.trs_b = trs;
        @(posedge i_clk);
        if (i_std inside {3'h2, 3'h4, 3'h6}) begin
            @(posedge i_clk);
        end
        @(negedge i_clk);
    endtask
endmodule

// [testbench/vstx_input_test.sv]
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module vstx_input_test;
    // Reflected form of x^18 + x^5 + x^4 + 1 for an lsb-first shift.
    localparam logic [17:0] CRC_POLY_REFL = 18'h23000;
    logic clk;
    logic rst;
    logic crc_en;
    logic ln_en;
    logic [2:0] std_sel;
    logic [10:0] line_num;
    vstx_pkg::vstx_stream_t src_stream;
    vstx_pkg::vstx_stream_t out_stream;
    vstx_pkg::vstx_std_t out_std;
    logic valid_gen;
    logic valid_gen_b;
    int mismatches;
    int checks_done;

    // Clock at 20 MHz.
    always #25 clk = ~clk;

    vstx_input u_dut (
        .i_clk(clk),
        .i_rst(rst),
        .i_std(std_sel),
        .i_crc_insert_enable(crc_en),
        .i_line_number_insert_enable(ln_en),
        .i_line_number(line_num),
        .i_stream(src_stream),
        .o_stream(out_stream),
        .o_std(out_std),
        .o_valid_gen(valid_gen),
        .o_valid_gen_b(valid_gen_b)
    );

    vstx_source u_src (
        .i_clk(clk),
        .i_std(std_sel),
        .o_stream(src_stream)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts the outcome.
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Advances a line CRC by one ten-bit word, lsb first.
    function automatic logic [17:0] crc_step(input logic [17:0] c, input logic [9:0] w);
        logic [17:0] r;
        r = c;
        for (int b = 0; b < 10; b++) begin
            r = (r >> 1) ^ ((r[0] ^ w[b]) ? CRC_POLY_REFL : 18'h00000);
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Walks every select code and checks the registered standard.
    task automatic test_std_decode();
        vstx_pkg::vstx_std_t exp_tab [8];
        exp_tab = '{vstx_pkg::STD_SD, vstx_pkg::STD_HD, vstx_pkg::STD_3GB, vstx_pkg::STD_3GA,
                    vstx_pkg::STD_6G8, vstx_pkg::STD_6G4, vstx_pkg::STD_12G16, vstx_pkg::STD_12G8};
        for (int c = 0; c < 8; c++) begin
            std_sel = 3'(c);
            @(posedge clk);
            @(negedge clk);
            check(80'(out_std), 80'(exp_tab[c]));
        end
    endtask

    // Changes the standard and follows two periods of the generated valid.
    task automatic test_cadence(input logic [2:0] s, input int period, input int h1);
        std_sel = s;
        for (int i = 0; i < 2 * period; i++) begin
            @(posedge clk);
            @(negedge clk);
            check(80'(valid_gen), 80'((i % period == 0) || (i % period == h1)));
            check(80'(valid_gen_b), 80'h0);
        end
    endtask

    // Sends SAV, three active words, EAV and four words; checks insertion or passthrough.
    task automatic test_line(input logic [2:0] s, input int nf, input logic crc_on, input logic ln_on);
        logic [9:0] wtab [15];
        logic [17:0] crc [8];
        logic [79:0] exp;
        logic [79:0] mask;
        logic [9:0] f;
        logic ln_ins;
        logic crc_ins;
        wtab = '{10'h3FF, 10'h000, 10'h000, 10'h200, 10'h155, 10'h2AA, 10'h0F0, 10'h3FF,
                 10'h000, 10'h000, 10'h274, 10'h111, 10'h222, 10'h333, 10'h044};
        ln_ins = ln_on && (s != 3'h0);
        crc_ins = crc_on && (s != 3'h0);
        std_sel = s;
        crc_en = crc_on;
        ln_en = ln_on;
        exp = '0;
        mask = '0;
        @(posedge clk);
        @(negedge clk);
        for (int k = 0; k < nf; k++) begin
            mask[10*k +: 10] = 10'h3FF;
        end
        for (int i = 0; i < 15; i++) begin
            u_src.put(wtab[i], i == 0 || i == 7);
            for (int k = 0; k < 8; k++) begin
                f = wtab[i] ^ 10'(k);
                if (ln_ins && i == 11) f = {~line_num[6], line_num[6:0], 2'b00};
                if (ln_ins && i == 12) f = {1'b1, 3'b000, line_num[10:7], 2'b00};
                if (crc_ins && i == 13) f = {~crc[k][8], crc[k][8:0]};
                if (crc_ins && i == 14) f = {~crc[k][17], crc[k][17:9]};
                if (i == 3) crc[k] = 18'h00000;
                if (i > 3 && i < 13) crc[k] = crc_step(crc[k], f);
                exp[10*k +: 10] = f;
            end
            check(out_stream.data & mask, exp & mask);
            check(80'(out_stream.trs), 80'(i == 0 || i == 7));
            check(80'({out_stream.valid, out_stream.valid_b, out_stream.trs_b, out_stream.data_b}),
                  80'({1'b1, 1'b1, i == 0 || i == 7, src_stream.data_b}));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, then each scenario in turn.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        std_sel = 3'h0;
        crc_en = 1'b0;
        ln_en = 1'b0;
        line_num = 11'h5A3;
        mismatches = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check(out_stream.data, 80'h0);
        check(80'({out_stream.data_b, out_stream.valid, out_stream.valid_b, out_stream.trs, out_stream.trs_b}), 80'h0);
        check(80'(out_std), 80'(vstx_pkg::STD_SD));
        check(80'({valid_gen, valid_gen_b}), 80'h0);
        rst = 1'b0;
        test_std_decode();
        test_cadence(3'h0, 11, 5);
        test_cadence(3'h1, 2, 0);
        test_cadence(3'h3, 1, 0);
        test_line(3'h7, 8, 1'b0, 1'b0);
        test_line(3'h0, 1, 1'b1, 1'b1);
        test_line(3'h1, 2, 1'b1, 1'b1);
        test_line(3'h1, 2, 1'b0, 1'b1);
        finish_test();
    end

    // Watchdog: the scenarios need well under a thousand cycles, so 5000 means a hang.
    initial begin
        #250000;
        mismatches++;
        finish_test();
    end
endmodule
